// file: rtl/adcseq_top.sv
/*
  Conversion sequencer: serial byte receiver, result FIFO with byte reads,
  four clock modes, averaging, temperature ordering and end-of-conversion.
  Assumes an analog core with a req/done handshake returning offset-binary
  codes, and a serial clock far slower than clk.
*/
// Function
// R1: Bipolar and temperature results in two's complement
// R2: Partial first byte read skips to second
// R3: Partial second byte drops rest, keeps FIFO
// R4: Write aborted before eight clocks is ignored
// R5: Host waits for end-of-conversion before select
// R6: Mode 00 scan starts on pin low pulse
// R7: Modes 00/10 scan, store, shut down, flag
// R8: Temperature result precedes all channel results
// R9: Host no new start before end-of-conversion
// R10: Mode 01 host holds start low 1.4us
// R11: Mode 01 internal reference adds 45us
// R12: Mode 01 temperature timed internally
// R13: Mode 01 rising edge samples, converts, flags
// R14: Flag held low until select or start; start falling releases it only outside mode 10
// R15: Host gives one pulse per conversion
// R16: Averaged result stored, then next channel
// R17: Mode 01 temperature on first edge after command
// R18: Mode 10 default; command byte starts scan
// R19: Mode 11 single sclk conversion, no FIFO
// R20: Mode 11 host sends sixteen clocks after command
// R21: Mode 11 host interleaves one no-op byte
// R22: Two no-ops power down unless bias kept
// R23: Result as two bytes, four leading zeros
`timescale 1ns/1ps
module adcseq_top #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial port pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic dout,
  // Conversion start and end pins
  input wire logic conv_start_n,
  output logic eoc_n,
  // Configuration
  input wire logic [1:0] clock_mode,
  input wire logic [3:0] scan_last,
  input wire logic [2:0] avg_log2,
  input wire logic temp_req,
  input wire logic bipolar,
  input wire logic bias_keep_on,
  // Analog core
  output logic analog_on,
  output logic adc_req,
  output logic adc_temp,
  output logic [3:0] adc_chan,
  input wire logic adc_done,
  input wire logic [11:0] adc_data,
  // Status
  output logic [4:0] fifo_level
);

  localparam int PW = $clog2(DEPTH);
  localparam int SAMP_LO = int'(adcseq_pkg::SAMP_CYC);
  localparam int SAMP_HI = SAMP_LO + 3;

  typedef struct packed {
    adcseq_pkg::adcseq_fsm_type state;
    logic [10:0] wait_cnt;
    logic [3:0] chan;
    logic [3:0] avg_cnt;
    logic [15:0] acc;
    logic temp_pend;
    logic is_temp;
    logic armed;
    logic [7:0] rx_sh;
    logic [3:0] bit_cnt;
    logic byte_sel;
    logic [7:0] tx_sh;
    logic [15:0] m11_sh;
    logic [1:0] nop_cnt;
    logic sclk_d;
    logic cs_d;
    logic cst_d;
    logic eoc_n;
    logic analog_on;
    logic adc_req;
    logic dout;
    logic [DEPTH-1:0][11:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [4:0] count;
  } adcseq_state_type;

  adcseq_state_type q, d;
  logic [3:0] pin_s;
  logic cs_s, sclk_s, mosi_s, cst_s;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, cst_rise, cst_fall;
  logic byte_ev, conv_cmd, nop_cmd, adv, push, pop, fifo_empty;
  logic [7:0] rx_byte, cur_byte;
  logic [11:0] push_data;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edges

  adcseq_sync #(.W(4)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({~cs_n, sclk, mosi, ~conv_start_n}),
    .sync_out(pin_s)
  );

  // Active-low pins pass inverted: a cleared synchroniser then reads idle, no false edge
  assign {cs_s, sclk_s, mosi_s, cst_s} = pin_s ^ 4'h9;
  assign sclk_rise = sclk_s & ~q.sclk_d;
  assign sclk_fall = ~sclk_s & q.sclk_d;
  assign cs_rise = cs_s & ~q.cs_d;
  assign cs_fall = ~cs_s & q.cs_d;
  assign cst_rise = cst_s & ~q.cst_d;
  assign cst_fall = ~cst_s & q.cst_d;
  assign fifo_empty = (q.count == 5'h00);
  assign rx_byte = {q.rx_sh[6:0], mosi_s};
  // Four zeros and the high four bits, then the low eight bits
  assign cur_byte = fifo_empty ? adcseq_pkg::TX_RESET :
                    q.byte_sel ? q.mem[q.rd_ptr][7:0] :
                    {adcseq_pkg::LEAD_ZEROS, q.mem[q.rd_ptr][11:8]}; // see R23

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [11:0] code;
    logic [15:0] acc_n;
    logic last_avg;
    code = '0;
    acc_n = '0;
    last_avg = 1'b0;
    d = q;
    byte_ev = 1'b0;
    adv = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_data = '0;
    d.sclk_d = sclk_s;
    d.cs_d = cs_s;
    d.cst_d = cst_s;

    // Serial receive; a byte counts only after all eight clocks
    if (cs_fall) begin
      d.bit_cnt = '0;
      d.tx_sh = cur_byte;
    end
    if (!cs_s && sclk_rise) begin
      d.rx_sh = rx_byte;
      if (q.bit_cnt == adcseq_pkg::BITS_PER_BYTE - 4'h1) begin
        byte_ev = 1'b1;
        adv = 1'b1;
        d.bit_cnt = '0;
      end else begin
        d.bit_cnt = q.bit_cnt + 4'h1;
      end
    end
    if (cs_rise && q.bit_cnt != 4'h0) begin
      adv = 1'b1; // see R2, R3, R4
      d.bit_cnt = '0;
    end
    if (!cs_s && sclk_fall) begin
      d.tx_sh = (q.bit_cnt == 4'h0) ? cur_byte : {q.tx_sh[6:0], 1'b0}; // see R23
    end
    if (!cs_s && sclk_rise && clock_mode == adcseq_pkg::MODE_SCLK) begin
      d.m11_sh = {q.m11_sh[14:0], 1'b0}; // see R19
    end
    conv_cmd = byte_ev && rx_byte[adcseq_pkg::CONV_CMD_BIT];
    nop_cmd = byte_ev && rx_byte == adcseq_pkg::NOP_BYTE;

    // Unread bits of a half-read byte are dropped
    if (adv && !fifo_empty && clock_mode != adcseq_pkg::MODE_SCLK) begin
      d.byte_sel = ~q.byte_sel; // see R2, R3
      pop = q.byte_sel;
    end

    // End-of-conversion released by select falling, or by start falling outside mode 10
    if (cs_fall || (cst_fall && clock_mode != adcseq_pkg::MODE_CMD_SCAN)) begin
      d.eoc_n = 1'b1; // see R14
    end

    // Two no-ops after a conversion byte put the analog cells to sleep
    if (clock_mode == adcseq_pkg::MODE_SCLK && nop_cmd && q.state == adcseq_pkg::ST_IDLE) begin
      if (q.nop_cnt != adcseq_pkg::NOPS_TO_SLEEP) begin
        d.nop_cnt = q.nop_cnt + 2'h1;
      end
      if (q.nop_cnt + 2'h1 == adcseq_pkg::NOPS_TO_SLEEP && !bias_keep_on) begin
        d.analog_on = 1'b0; // see R22
      end
    end

    case (q.state)
      adcseq_pkg::ST_IDLE: begin
        if ((clock_mode == adcseq_pkg::MODE_PIN_SCAN && cst_rise) ||
            (clock_mode == adcseq_pkg::MODE_CMD_SCAN && conv_cmd)) begin
          d.state = adcseq_pkg::ST_WAKE; // see R6, R18
          d.wait_cnt = adcseq_pkg::ACQ_CYC;
          d.analog_on = 1'b1;
          d.chan = '0;
          d.avg_cnt = '0;
          d.acc = '0;
          d.temp_pend = temp_req;
          d.wr_ptr = '0;
          d.rd_ptr = '0;
          d.count = '0;
          d.byte_sel = 1'b0;
        end else if (clock_mode == adcseq_pkg::MODE_PIN_EACH) begin
          if (conv_cmd) begin
            d.armed = 1'b1;
            d.temp_pend = temp_req; // see R17
            d.chan = '0;
            d.avg_cnt = '0;
            d.acc = '0;
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count = '0;
            d.byte_sel = 1'b0;
          end else if (q.armed && cst_fall) begin
            d.analog_on = 1'b1; // Tracking while start is low
          end else if (q.armed && cst_rise) begin
            d.analog_on = 1'b1;
            d.state = q.temp_pend ? adcseq_pkg::ST_TEMP : adcseq_pkg::ST_SAMP; // see R12, R17
            d.wait_cnt = q.temp_pend ? adcseq_pkg::REF_CYC : adcseq_pkg::SAMP_CYC; // see R13
          end
        end else if (clock_mode == adcseq_pkg::MODE_SCLK && conv_cmd) begin
          d.state = adcseq_pkg::ST_CONV; // see R19
          d.adc_req = 1'b1;
          d.is_temp = temp_req;
          d.analog_on = 1'b1;
          d.nop_cnt = '0;
        end
      end
      adcseq_pkg::ST_WAKE: begin
        d.wait_cnt = q.wait_cnt - 11'h1;
        if (q.wait_cnt == 11'h1) begin
          d.state = q.temp_pend ? adcseq_pkg::ST_TEMP : adcseq_pkg::ST_SAMP; // see R8
          d.wait_cnt = q.temp_pend ? adcseq_pkg::REF_CYC : 11'h1;
        end
      end
      adcseq_pkg::ST_TEMP, adcseq_pkg::ST_SAMP: begin
        d.wait_cnt = q.wait_cnt - 11'h1;
        if (q.wait_cnt <= 11'h1) begin
          d.state = adcseq_pkg::ST_CONV;
          d.adc_req = 1'b1;
          d.is_temp = (q.state == adcseq_pkg::ST_TEMP);
        end
      end
      adcseq_pkg::ST_CONV: begin
        if (adc_done) begin
          d.adc_req = 1'b0;
          if (clock_mode == adcseq_pkg::MODE_SCLK) begin
            code = adc_data ^ ((q.is_temp || bipolar) ? adcseq_pkg::SIGN_FLIP : 12'h000);
            d.m11_sh = {adcseq_pkg::LEAD_ZEROS, code}; // see R1, R19
            d.is_temp = 1'b0;
            d.state = adcseq_pkg::ST_IDLE;
          end else if (q.is_temp) begin
            push = 1'b1;
            push_data = adc_data ^ adcseq_pkg::SIGN_FLIP; // see R1, R8
            d.temp_pend = 1'b0;
            d.is_temp = 1'b0;
            d.state = (clock_mode == adcseq_pkg::MODE_PIN_EACH) ? adcseq_pkg::ST_DONE :
                      adcseq_pkg::ST_SAMP;
            d.wait_cnt = 11'h1;
          end else begin
            acc_n = q.acc + {4'h0, adc_data};
            last_avg = (q.avg_cnt == 4'((5'h01 << avg_log2) - 5'h01));
            d.acc = acc_n;
            d.avg_cnt = q.avg_cnt + 4'h1;
            d.state = (clock_mode == adcseq_pkg::MODE_PIN_EACH) ? adcseq_pkg::ST_DONE :
                      adcseq_pkg::ST_SAMP;
            d.wait_cnt = 11'h1;
            if (last_avg) begin
              push = 1'b1; // see R16
              push_data = (12'(acc_n >> avg_log2)) ^
                          (bipolar ? adcseq_pkg::SIGN_FLIP : 12'h000); // see R1
              d.acc = '0;
              d.avg_cnt = '0;
              d.chan = q.chan + 4'h1;
              if (q.chan == scan_last) begin
                d.chan = '0;
                d.armed = 1'b0;
                d.state = adcseq_pkg::ST_DONE; // see R7
              end
            end
          end
        end
      end
      adcseq_pkg::ST_DONE: begin
        d.analog_on = 1'b0;
        d.eoc_n = 1'b0; // see R7, R13
        d.state = adcseq_pkg::ST_IDLE;
      end
      default: begin
        d.state = adcseq_pkg::ST_IDLE;
      end
    endcase

    // FIFO bookkeeping; pushes beyond depth are lost
    if (push && q.count != 5'(DEPTH)) begin
      d.mem[d.wr_ptr] = push_data;
      d.wr_ptr = d.wr_ptr + PW'(1);
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + PW'(1);
    end
    d.count = d.count + ((push && q.count != 5'(DEPTH)) ? 5'h01 : 5'h00) -
              (pop ? 5'h01 : 5'h00);
    d.dout = (clock_mode == adcseq_pkg::MODE_SCLK) ? d.m11_sh[15] : d.tx_sh[7];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= adcseq_pkg::ST_IDLE;
      q.eoc_n <= 1'b1;
      q.cs_d <= 1'b1;
      q.cst_d <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign dout = q.dout;
  assign eoc_n = q.eoc_n;
  assign analog_on = q.analog_on;
  assign adc_req = q.adc_req;
  assign adc_temp = q.is_temp;
  assign adc_chan = q.chan;
  assign fifo_level = q.count;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_eoc_release: assert property (cs_fall |=> eoc_n) // see R14
    else $error("end-of-conversion not released by select");
  a_write_abort: assert property (cs_rise && q.bit_cnt != 4'h0 |-> !byte_ev) // see R4
    else $error("aborted write took effect");
  a_first_partial: assert property (cs_rise && q.bit_cnt != 4'h0 && !fifo_empty &&
      !q.byte_sel && clock_mode != adcseq_pkg::MODE_SCLK |=> q.byte_sel) // see R2
    else $error("partial first byte did not move to second");
  a_second_partial: assert property (cs_rise && q.bit_cnt != 4'h0 && !fifo_empty &&
      q.byte_sel && !push && clock_mode != adcseq_pkg::MODE_SCLK
      |=> fifo_level == $past(fifo_level) - 5'h01 && !q.byte_sel) // see R3
    else $error("partial second byte did not drop exactly one entry");
  a_done_shutdown: assert property (q.state == adcseq_pkg::ST_DONE
      |=> !eoc_n && !analog_on ##1 !eoc_n || cs_fall || cst_fall) // see R7
    else $error("scan end did not shut down and flag");
  a_temp_first: assert property (push && q.is_temp |-> fifo_level == 5'h00) // see R8
    else $error("temperature result not first in FIFO");
  a_sclk_no_fifo: assert property (clock_mode == adcseq_pkg::MODE_SCLK |-> !push) // see R19
    else $error("FIFO written in serial-clocked mode");
  a_mode10_start: assert property (clock_mode == adcseq_pkg::MODE_CMD_SCAN && conv_cmd &&
      q.state == adcseq_pkg::ST_IDLE |=> q.state == adcseq_pkg::ST_WAKE && analog_on) // see R18
    else $error("command byte did not start scan");
  a_sample_delay: assert property (clock_mode == adcseq_pkg::MODE_PIN_EACH && q.armed &&
      !q.temp_pend && cst_rise && q.state == adcseq_pkg::ST_IDLE
      |-> ##[SAMP_LO:SAMP_HI] adc_req) // see R13
    else $error("sampling did not end on time after start edge");
  a_bias_sleep: assert property (clock_mode == adcseq_pkg::MODE_SCLK && nop_cmd &&
      q.state == adcseq_pkg::ST_IDLE && q.nop_cnt == 2'h1 && !bias_keep_on
      |=> !analog_on) // see R22
    else $error("analog cells not powered down after two no-ops");
  a_avg_push: assert property (push && !q.is_temp |->
      q.avg_cnt == 4'((5'h01 << avg_log2) - 5'h01)) // see R16
    else $error("result stored before averaging completed");
  a_temp_code: assert property (push && q.is_temp |-> push_data[11] != adc_data[11]) // see R1
    else $error("temperature result not two's complement");

endmodule

// file: rtl/adcseq_pkg.sv
/*
  Package for the conversion sequencer: state encoding, clock-mode codes,
  timing figures and the cycle counts derived from them.
  Assumes a 25 MHz block clock.
*/
package adcseq_pkg;

  // Block clock
  localparam int CLK_NS = 40;

  // Sampling ends about this long after the start edge in mode 01
  localparam int SAMP_NS = 500;
  localparam logic [10:0] SAMP_CYC = 11'(SAMP_NS / CLK_NS);
  // Acquisition after wake-up in the internally timed modes
  localparam int ACQ_NS = 1400;
  localparam logic [10:0] ACQ_CYC = 11'((ACQ_NS + CLK_NS - 1) / CLK_NS);
  // Reference power-up before a temperature conversion
  localparam int REF_NS = 45000;
  localparam logic [10:0] REF_CYC = 11'((REF_NS + CLK_NS - 1) / CLK_NS);

  // Clock modes
  localparam logic [1:0] MODE_PIN_SCAN = 2'h0;
  localparam logic [1:0] MODE_PIN_EACH = 2'h1;
  localparam logic [1:0] MODE_CMD_SCAN = 2'h2;
  localparam logic [1:0] MODE_SCLK = 2'h3;

  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] NOP_BYTE = 8'h00;
  localparam int CONV_CMD_BIT = 7;
  localparam logic [1:0] NOPS_TO_SLEEP = 2'h2;

  // Offset-binary to two's complement flip
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [3:0] LEAD_ZEROS = 4'h0;

  // Reset values
  localparam logic [7:0] TX_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_TEMP = 3'b011,
    ST_SAMP = 3'b010,
    ST_CONV = 3'b110,
    ST_DONE = 3'b111
  } adcseq_fsm_type;

endpackage

// file: rtl/adcseq_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous level inputs.
  Assumes the inputs carry no multi-bit value that must stay coherent.
*/
`timescale 1ns/1ps
module adcseq_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } adcseq_sync_type;

  adcseq_sync_type q, d;

  always_comb begin
    d = q;
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule

// file: tb/adcseq_host.sv
/*
  Host model: serial master and conversion-start driver.
  Assumes clk is the block clock; sclk half period is four clk cycles (320 ns period).
*/
`timescale 1ns/1ps
module adcseq_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic dout,
  // Start pin
  output logic conv_start_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
    conv_start_n = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Fewer than eight bits models an aborted frame
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    cs_n = 1'b0;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi = tx[i];
      tick(4);
      rx[i] = dout;
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    // Released data line must not keep its last level
    mosi = ~mosi;
    tick(8);
  endtask

  // Callers wait for end-of-conversion first; a start edge while the sequencer is busy is ignored
  task automatic start_pulse(input int low_cyc);
    conv_start_n = 1'b0;
    tick(low_cyc);
    conv_start_n = 1'b1;
  endtask
endmodule

// file: tb/testbench.sv
/*
  Self-checking bench for the conversion sequencer with an analog core model.
  Assumes the host model is compiled first and the design uses its own package.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, sys_rst, cs_n, sclk, mosi, dout, conv_start_n, eoc_n;
  logic [1:0] clock_mode;
  logic [3:0] scan_last, adc_chan;
  logic [2:0] avg_log2, core_cnt;
  logic temp_req, bipolar, bias_keep_on, analog_on, adc_req, adc_temp, adc_done;
  logic [11:0] adc_data, e;
  logic [4:0] fifo_level;
  logic [7:0] rx;
  logic wobble, jit;
  int error_cnt, n_compared, n_done, n0;
  localparam logic [11:0] TEMP_CODE = 12'h123;

  function automatic logic [11:0] code(input logic [3:0] c);
    return 12'h9a0 + {8'h00, c};
  endfunction

  adcseq_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .dout(dout),
    .conv_start_n(conv_start_n));

  adcseq_top #(.DEPTH(16)) dut_u (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .dout(dout), .conv_start_n(conv_start_n), .eoc_n(eoc_n),
    .clock_mode(clock_mode), .scan_last(scan_last), .avg_log2(avg_log2),
    .temp_req(temp_req), .bipolar(bipolar), .bias_keep_on(bias_keep_on),
    .analog_on(analog_on), .adc_req(adc_req), .adc_temp(adc_temp), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .fifo_level(fifo_level));

  ////////////////////////////////////////////////////////////////////////////////
  // Analog core: answers five cycles after a request; jit spreads samples by +-1
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_done <= 1'b0;
      core_cnt <= 3'h0;
      adc_data <= 12'h000;
      wobble <= 1'b0;
    end else begin
      adc_done <= adc_req && core_cnt == 3'h4 && !adc_done;
      core_cnt <= (adc_req && !adc_done) ? core_cnt + 3'h1 : 3'h0;
      if (adc_req && core_cnt == 3'h4 && !adc_done) begin
        adc_data <= (adc_temp ? TEMP_CODE : code(adc_chan)) +
          (jit ? (wobble ? 12'h001 : 12'hfff) : 12'h000);
        wobble <= ~wobble;
        n_done <= n_done + 1;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input int n, input logic [7:0] exp);
    host_u.xfer(8'h00, n, rx);
    if (n == 8) begin
      chk("dout byte", {4'h0, exp}, {4'h0, rx});
    end
  endtask

  task automatic rd_entry(input logic [11:0] v);
    rd(8, {4'h0, v[11:8]});
    rd(8, v[7:0]);
  endtask

  task automatic wait_eoc;
    for (int i = 0; i < 4000 && eoc_n !== 1'b0; i++) host_u.tick(1);
    chk("eoc_n low", 12'h000, {11'h000, eoc_n});
  endtask

  task automatic cfg(input logic [1:0] m, input logic [3:0] l, input logic [2:0] a,
      input logic t, input logic b);
    clock_mode = m;
    scan_last = l;
    avg_log2 = a;
    temp_req = t;
    bipolar = b;
  endtask

  task automatic tally_and_finish;
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Full run is near seven thousand cycles
  initial begin
    #2000000;
    error_cnt++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    cfg(2'h2, 4'h0, 3'h0, 1'b0, 1'b0);
    bias_keep_on = 1'b0;
    jit = 1'b0;
    n_done = 0;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    host_u.tick(2);
    chk("eoc_n reset", 12'h001, {11'h000, eoc_n});
    chk("analog_on reset", 12'h000, {11'h000, analog_on});
    chk("fifo_level reset", 12'h000, {7'h00, fifo_level});
    host_u.xfer(8'h80, 5, rx);
    host_u.tick(20);
    chk("analog_on abort", 12'h000, {11'h000, analog_on});
    // Command scan with temperature
    cfg(2'h2, 4'h2, 3'h0, 1'b1, 1'b0);
    host_u.xfer(8'h80, 8, rx);
    host_u.tick(4);
    chk("analog_on scan", 12'h001, {11'h000, analog_on});
    wait_eoc();
    chk("analog_on done", 12'h000, {11'h000, analog_on});
    chk("fifo_level scan", 12'h004, {7'h00, fifo_level});
    rd_entry(TEMP_CODE ^ 12'h800);
    chk("eoc_n released", 12'h001, {11'h000, eoc_n});
    for (int c = 0; c < 3; c++) rd_entry(code(4'(c)));
    // Pin scan, bipolar, partial reads
    cfg(2'h0, 4'h2, 3'h0, 1'b0, 1'b1);
    host_u.start_pulse(1);
    wait_eoc();
    rd(3, 8'h00);
    e = code(4'h0) ^ 12'h800;
    rd(8, e[7:0]);
    e = code(4'h1) ^ 12'h800;
    rd(8, {4'h0, e[11:8]});
    rd(5, 8'h00);
    rd_entry(code(4'h2) ^ 12'h800);
    chk("fifo_level drained", 12'h000, {7'h00, fifo_level});
    // Averaging, two then four samples per result; the wider scan is bipolar
    jit = 1'b1;
    for (int a = 1; a < 3; a++) begin
      cfg(2'h2, 4'(a), 3'(a), 1'b0, a[1]);
      n0 = n_done;
      host_u.xfer(8'h80, 8, rx);
      wait_eoc();
      chk("conversions", 12'((a + 1) << a), 12'(n_done - n0));
      chk("fifo_level avg", 12'(a + 1), {7'h00, fifo_level});
      rd_entry(code(4'h0) ^ {a[1], 11'h000});
      for (int c = 1; c <= a; c++) begin
        rd_entry(code(4'(c)) ^ {a[1], 11'h000});
      end
    end
    jit = 1'b0;
    // Pin per conversion, temperature on first edge
    cfg(2'h1, 4'h0, 3'h0, 1'b1, 1'b0);
    host_u.xfer(8'h80, 8, rx);
    host_u.start_pulse(1);
    wait_eoc();
    chk("fifo_level temp", 12'h001, {7'h00, fifo_level});
    host_u.start_pulse(35 + 1125);
    chk("eoc_n start fall", 12'h001, {11'h000, eoc_n});
    host_u.tick(10);
    chk("adc_req early", 12'h000, {11'h000, adc_req});
    wait_eoc();
    rd_entry(TEMP_CODE ^ 12'h800);
    rd_entry(code(4'h0));
    // Serial-clocked mode: command then two no-op bytes
    for (int k = 0; k < 2; k++) begin
      cfg(2'h3, 4'h0, 3'h0, k[0], 1'b0);
      bias_keep_on = k[0];
      host_u.xfer(8'h80, 8, rx);
      rd_entry(k[0] ? TEMP_CODE ^ 12'h800 : code(4'h0));
      host_u.tick(4);
      chk("analog_on no-ops", {11'h000, k[0]}, {11'h000, analog_on});
      chk("fifo_level sclk", 12'h000, {7'h00, fifo_level});
    end
    tally_and_finish();
  end
endmodule
